// >>> tnp_pkg.sv
`default_nettype none
package tnp_pkg;
	// Stream geometry
	localparam int unsigned NIB_W = 4;
	localparam logic [4:0] WORD_NIBS = 5'h10;
	localparam logic [2:0] FULL_BYTES_M1 = 3'h7;
	localparam logic [3:0] NULL_NIB = 4'h0;
	// Master numbers are always carried in one byte
	localparam logic [4:0] MASTER_NIBS = 5'h02;
	// Values after reset, and the default ATB ID (reset clears id to zero)
	localparam logic [4:0] RST_CNT = 5'h00;
	localparam logic [4:0] RST_IDX = 5'h00;
	localparam logic [63:0] RST_WORD = 64'h0;
	localparam logic [6:0] DEF_ATID = 7'h10;

	typedef enum logic [3:0] {
		K_CHAN,
		K_MASTER8,
		K_DATA,
		K_DATA_STAMP,
		K_TSTAMP,
		K_FLAG,
		K_MASTER16,
		K_TIME,
		K_NULL_STAMP,
		K_USER,
		K_FREQ_STAMP,
		K_CROSS_SYNC
	} tnp_kind_e;

	typedef enum logic {
		PH_IDLE,
		PH_EMIT
	} tnp_phase_e;

	// One packet field offered by the packet generator
	typedef struct packed {
		tnp_kind_e kind;
		logic [7:0] op;
		logic [1:0] op_nibs;
		logic [63:0] val;
		logic [4:0] val_nibs;
	} tnp_field_s;

	// One ATB transfer as driven toward the sink
	typedef struct packed {
		logic valid;
		logic [63:0] data;
		logic [2:0] bytes;
		logic [6:0] id;
	} tnp_atb_s;

	typedef struct packed {
		logic stim_port_trigger_out;
		logic software_trigger_out;
		logic hw_event_trigger_out;
		logic sync_marker_out;
	} tnp_trig_s;

	typedef struct packed {
		tnp_phase_e ph;
		tnp_field_s f;
		logic [4:0] idx;
		logic [63:0] w;
		logic [4:0] cnt;
		logic rdy;
		tnp_atb_s atb;
		logic fl_ack;
		logic drop;
		tnp_trig_s trig;
		logic itm;
	} tnp_state_s;
endpackage : tnp_pkg
`default_nettype wire

// >>> tnp_packer.sv
`default_nettype none
module tnp_packer
	import tnp_pkg::*;
#(
	parameter logic [6:0] ATB_ID = DEF_ATID
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Packet fields from the generator
	input wire tnp_field_s fld,
	input wire logic fld_valid,
	output logic fld_ready,
	output logic drop_pulse,
	// ATB master
	output tnp_atb_s atb,
	input wire logic atready,
	input wire logic afvalid,
	output logic afready,
	// Triggers and integration mode
	input wire logic integration_mode_enable,
	input wire tnp_trig_s trig_in,
	input wire tnp_trig_s it_trig,
	input wire tnp_atb_s it_atb,
	output tnp_trig_s trig_out
);

	tnp_state_s s;
	tnp_state_s next;
	logic [3:0] cur_nib;
	logic [4:0] last_idx;

	// Kinds that this source must never put on the trace bus
	function automatic logic tnp_forbidden(input tnp_kind_e k);
		tnp_forbidden = 1'b0;
		case (k)
			K_MASTER16: tnp_forbidden = 1'b1;
			K_TIME: tnp_forbidden = 1'b1;
			K_NULL_STAMP: tnp_forbidden = 1'b1;
			K_FREQ_STAMP: tnp_forbidden = 1'b1;
			K_USER: tnp_forbidden = 1'b1;
			K_CROSS_SYNC: tnp_forbidden = 1'b1;
			default: tnp_forbidden = 1'b0;
		endcase
	endfunction : tnp_forbidden

	// Nibble idx of the field stream: opcode, optional size, then value
	function automatic logic [3:0] tnp_nib(input tnp_field_s f, input logic [4:0] idx);
		logic [4:0] j;
		logic [4:0] p;
		logic [4:0] opn;
		tnp_nib = NULL_NIB;
		opn = {3'h0, f.op_nibs};
		j = 5'h00;
		p = 5'h00;
		if (idx < opn) begin
			j = 5'(opn - idx - 5'h01);
			tnp_nib = f.op[{j[0], 2'b00} +: 4];
		end else begin
			j = 5'(idx - opn);
			if (f.kind == K_TSTAMP && j == 5'h00) begin
				tnp_nib = f.val_nibs[3:0];
			end else begin
				if (f.kind == K_TSTAMP) begin
					j = 5'(j - 5'h01);
				end
				p = 5'(f.val_nibs - j - 5'h01);
				tnp_nib = f.val[{p[3:0], 2'b00} +: 4];
			end
		end
	endfunction : tnp_nib

	// Current nibble and index of the field's final nibble
	always_comb begin
		cur_nib = tnp_nib(s.f, s.idx);
		last_idx = 5'({3'h0, s.f.op_nibs} + s.f.val_nibs
			+ ((s.f.kind == K_TSTAMP) ? 5'h01 : 5'h00) - 5'h01);
	end

	// Next-state logic for the whole packer
	always_comb begin
		next = s;
		next.drop = 1'b0;
		next.fl_ack = 1'b0;
		// A plain input at a fixed position, no address involved
		next.itm = integration_mode_enable;
		if (s.atb.valid && atready) begin
			next.atb.valid = 1'b0;
		end
		if (s.itm) begin
			// Test drive reaches the pins through the state flops one cycle later; tracing assumed off
			next.atb = it_atb;
			next.trig = it_trig;
		end else begin
			next.trig = trig_in;
			case (s.ph)
				PH_IDLE: begin
					if (fld_valid && s.rdy) begin
						if (tnp_forbidden(fld.kind)) begin
							next.drop = 1'b1;
						end else begin
							// Fields go out strictly in arrival order
							next.f = fld;
							if (fld.kind == K_MASTER8) begin
								next.f.val_nibs = MASTER_NIBS;
							end
							next.idx = RST_IDX;
							next.ph = PH_EMIT;
						end
					end
				end
				PH_EMIT: begin
					// A full word stalls emission until it moves out
					if (s.cnt != WORD_NIBS) begin
						next.w[{s.cnt[3:0], 2'b00} +: 4] = cur_nib;
						next.cnt = 5'(s.cnt + 5'h01);
						next.idx = 5'(s.idx + 5'h01);
						if (s.idx >= last_idx) begin
							next.ph = PH_IDLE;
						end
					end
				end
				default: next.ph = PH_IDLE;
			endcase
			// Hand a full word to the ATB slot once it is free
			if (s.cnt == WORD_NIBS && !next.atb.valid) begin
				next.atb.valid = 1'b1;
				next.atb.data = s.w;
				next.atb.bytes = FULL_BYTES_M1;
				next.atb.id = ATB_ID;
				next.cnt = RST_CNT;
				next.w = RST_WORD;
			end else if (afvalid && s.ph == PH_IDLE && s.cnt != RST_CNT
				&& s.cnt != WORD_NIBS && !next.atb.valid) begin
				// Odd count leaves a zero nibble above, which is the filler
				next.atb.valid = 1'b1;
				next.atb.data = s.w;
				next.atb.bytes = 3'(((s.cnt + 5'h01) >> 1) - 5'h01);
				next.atb.id = ATB_ID;
				next.cnt = RST_CNT;
				next.w = RST_WORD;
			end else if (afvalid && s.ph == PH_IDLE && s.cnt == RST_CNT
				&& !s.atb.valid && !s.fl_ack) begin
				next.fl_ack = 1'b1;
			end
		end
		// Leaving integration mode needs a reset for clean tracing
		next.rdy = (next.ph == PH_IDLE) && !next.itm;
	end

	// State register; everything clears to zero under reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next;
		end
	end

	// Outputs straight from the state flops
	assign fld_ready = s.rdy;
	assign drop_pulse = s.drop;
	assign atb = s.atb;
	assign afready = s.fl_ack;
	assign trig_out = s.trig;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// A waiting transfer never changes under the sink outside integration mode
	a_atb_hold_stable: assert property (
		s.atb.valid && !atready && !s.itm && !next.itm |=> $stable(atb))
		else $error("ATB transfer changed before ready");

	a_m16_dropped: assert property (
		fld_valid && fld_ready && fld.kind == K_MASTER16 && !s.itm
		|=> drop_pulse && s.ph == PH_IDLE)
		else $error("16-bit master packet was accepted");

	a_time_dropped: assert property (
		fld_valid && fld_ready && fld.kind == K_TIME && !s.itm
		|=> drop_pulse ##1 fld_ready)
		else $error("time packet was accepted");

	a_cross_sync_dropped: assert property (
		fld_valid && fld_ready && fld.kind == K_CROSS_SYNC && !s.itm
		|=> !(s.ph == PH_EMIT))
		else $error("cross-sync packet was accepted");

	a_first_nib_low: assert property (
		s.ph == PH_EMIT && s.cnt == RST_CNT && !s.itm
		|=> s.w[3:0] == $past(cur_nib) && s.cnt == 5'h01)
		else $error("first nibble not at bits 3:0");

	a_value_msn_first: assert property (
		s.ph == PH_EMIT && s.f.kind != K_TSTAMP && s.f.val_nibs != 5'h00
		&& s.idx == {3'h0, s.f.op_nibs}
		|-> cur_nib == s.f.val[{4'(s.f.val_nibs - 5'h01), 2'b00} +: 4])
		else $error("value did not start at its top nibble");

	a_ts_size_nib: assert property (
		s.ph == PH_EMIT && s.f.kind == K_TSTAMP && s.idx == {3'h0, s.f.op_nibs}
		|-> cur_nib == s.f.val_nibs[3:0])
		else $error("timestamp size nibble wrong");

	a_full_word_out: assert property (
		s.cnt == WORD_NIBS && !s.atb.valid && !s.itm && !next.itm
		|=> atb.valid && atb.bytes == FULL_BYTES_M1 && s.cnt == RST_CNT)
		else $error("full word not handed out");

	a_short_pad_null: assert property (
		atb.valid && !s.itm && atb.bytes != FULL_BYTES_M1
		|-> atb.data[63:56] == 8'h00)
		else $error("short transfer carries data above its size");

	a_itm_mirror: assert property (
		s.itm && next.itm |=> trig_out == $past(it_trig))
		else $error("triggers do not follow integration drive");

	c_stamped_data: cover property (fld_valid && fld_ready && fld.kind == K_DATA_STAMP);
	c_short_flush: cover property (atb.valid && atb.bytes < FULL_BYTES_M1 && !s.itm);
	c_sink_stall: cover property (atb.valid && !atready ##1 atb.valid && atready);
	c_flush_ack: cover property (afvalid && afready);

endmodule : tnp_packer
`default_nettype wire

// >>> tnp_sink.sv
`default_nettype none
// Trace sink partner: takes ATB transfers, may stall, may ask for a flush
module tnp_sink
	import tnp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// ATB slave side
	input wire tnp_atb_s atb,
	output logic atready,
	output logic afvalid,
	input wire logic afready,
	// Bench controls
	input wire logic stall,
	input wire logic flush_req
);
	timeunit 1ns;
	timeprecision 1ps;
	tnp_atb_s got[$];
	tnp_atb_s held;
	logic pend;
	logic [1:0] slow;
	int errs = 0;
	// Registered ready keeps the sink no faster than a real one
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			got.delete();
			atready <= 1'b0;
			afvalid <= 1'b0;
			slow <= 2'h0;
			pend <= 1'b0;
		end else begin
			if (pend && atb !== held)
				errs <= errs + 1;
			if (atb.valid && atready)
				got.push_back(atb);
			pend <= atb.valid && !atready;
			held <= atb;
			slow <= slow + 2'h1;
			atready <= !stall || slow == 2'h3; // Slow mode answers one cycle in four
			afvalid <= !afready && (afvalid || flush_req);
		end
	end
endmodule : tnp_sink
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tnp_pkg::*;
	logic clock, rst_b, fld_valid, fld_ready, drop_pulse, atready, afvalid, afready;
	logic integration_mode_enable, stall, flush_req;
	tnp_field_s fld;
	tnp_atb_s atb, it_atb, w;
	tnp_trig_s trig_in, it_trig, trig_out;
	int miscompares = 0;
	int comparisons = 0;
	tnp_kind_e bad_kinds[6] = '{K_MASTER16, K_TIME, K_NULL_STAMP, K_USER, K_FREQ_STAMP,
		K_CROSS_SYNC};

	tnp_packer dut (.clock(clock), .rst_b(rst_b), .fld(fld), .fld_valid(fld_valid),
		.fld_ready(fld_ready), .drop_pulse(drop_pulse), .atb(atb), .atready(atready),
		.afvalid(afvalid), .afready(afready), .integration_mode_enable(integration_mode_enable),
		.trig_in(trig_in), .it_trig(it_trig), .it_atb(it_atb), .trig_out(trig_out));
	tnp_sink sink (.clock(clock), .rst_b(rst_b), .atb(atb), .atready(atready),
		.afvalid(afvalid), .afready(afready), .stall(stall), .flush_req(flush_req));

	// Free-running clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic wrap_up();
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Bounded wait: 0 field port free, 1 flush acknowledged, 2 a word reached the sink
	task automatic wait_on(input int what);
		int n;
		n = 0;
		while (!(what == 0 ? fld_ready === 1'b1 : what == 1 ? afready === 1'b1 :
				sink.got.size() > 0)) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 300) begin
				miscompares++;
				$display("BAD wait %0d expected done seen timeout", what);
				wrap_up();
			end
		end
	endtask : wait_on

	task automatic do_reset();
		rst_b = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		check("rst_data", atb.data, 64'h0);
		check("rst_ctl", 64'({atb.valid, atb.bytes, atb.id}), 64'h0);
		check("rst_hs", 64'({fld_ready, afready, drop_pulse, trig_out}), 64'h0);
		rst_b = 1'b1;
		repeat (2) @(posedge clock);
		#1;
	endtask : do_reset

	// Offer one field and return just after the edge that took it
	task automatic send(input tnp_kind_e k, input logic [7:0] op, input logic [1:0] on,
			input logic [63:0] v, input logic [4:0] vn);
		// One edge between calls, so fld_valid never falls and rises in one step
		@(posedge clock);
		#1;
		fld = '{k, op, on, v, vn};
		fld_valid = 1'b1;
		wait_on(0);
		@(posedge clock);
		#1 fld_valid = 1'b0;
	endtask : send

	task automatic flush_word(input string name, input logic [63:0] d, input logic [2:0] b);
		flush_req = 1'b1;
		@(posedge clock);
		#1 flush_req = 1'b0;
		wait_on(1);
		check({name, "_n"}, 64'(sink.got.size()), 64'h1);
		w = sink.got.pop_front();
		check(name, w.data, d);
		check({name, "_b"}, 64'(w.bytes), 64'(b));
	endtask : flush_word

	// Channel, stamped data and timestamp into a stalling sink
	task automatic t_order();
		stall = 1'b1;
		send(K_CHAN, 8'h03, 2'h1, 64'h14, 5'h02);
		send(K_DATA_STAMP, 8'hf6, 2'h2, 64'h12345678, 5'h08);
		send(K_TSTAMP, 8'h00, 2'h0, 64'h1234, 5'h04);
		wait_on(2);
		w = sink.got.pop_front();
		check("word0", w.data, 64'h21487654_3216f413);
		check("word0_b", 64'(w.bytes), 64'h7);
		check("word0_id", 64'(w.id), 64'(DEF_ATID));
		flush_word("tail", 64'h43, 3'h0);
		stall = 1'b0;
	endtask : t_order

	// Master number always one byte; odd remainder padded on flush
	task automatic t_master();
		send(K_MASTER8, 8'h01, 2'h1, 64'h85, 5'h04);
		flush_word("master", 64'h0581, 3'h1);
	endtask : t_master

	task automatic t_forbidden();
		foreach (bad_kinds[i]) begin
			send(bad_kinds[i], 8'hf0, 2'h2, 64'h5a, 5'h02);
			check("drop", 64'(drop_pulse), 64'h1);
		end
		repeat (20) @(posedge clock);
		#1;
		check("drop_n", 64'(sink.got.size()), 64'h0);
	endtask : t_forbidden

	// Trace stays idle while integration drive is looped onto the outputs
	task automatic t_integ();
		integration_mode_enable = 1'b1;
		// Only the defined integration controls are driven, nothing reserved
		it_trig = 4'h9;
		it_atb = '{1'b1, 64'h0123_4567_89ab_cdef, 3'h5, 7'h22};
		repeat (3) @(posedge clock);
		#1;
		check("it_trig", 64'(trig_out), 64'h9);
		check("it_data", atb.data, it_atb.data);
		check("it_ctl", 64'({atb.valid, atb.bytes, atb.id}), 64'h6a2);
		check("it_ready", 64'(fld_ready), 64'h0);
		integration_mode_enable = 1'b0;
		it_atb = '0;
		do_reset();
	endtask : t_integ

	initial begin
		fld = '0;
		fld_valid = 1'b0;
		integration_mode_enable = 1'b0;
		trig_in = 4'h6;
		it_trig = 4'h0;
		it_atb = '0;
		stall = 1'b0;
		flush_req = 1'b0;
		do_reset();
		check("trig_fn", 64'(trig_out), 64'h6);
		t_order();
		t_master();
		t_forbidden();
		t_integ();
		check("hold", 64'(sink.errs), 64'h0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
